// ==== ffgp_pkg.sv ====
// Package of offsets, fields and timing for the fault flag and indicator block
package ffgp_pkg;
  localparam int FFGP_AW = 8;
  // APB byte addresses
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_FLAGS = 8'h00;
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_STAT = 8'h04;
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_CTRL = 8'h08;
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_IRQ_STAT = 8'h0C;
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_IRQ_CLR = 8'h10;
  localparam logic [FFGP_AW-1:0] FFGP_ADDR_IRQ_EN = 8'h14;
  // Flag bit positions
  localparam int FFGP_NFLAG = 10;
  localparam int FFGP_B_WARM = 0;
  localparam int FFGP_B_HOT = 1;
  localparam int FFGP_B_ADC = 2;
  localparam int FFGP_B_CMP1 = 3;
  localparam int FFGP_B_CMP2 = 4;
  localparam int FFGP_B_CMP3 = 5;
  localparam int FFGP_B_OPEN = 6;
  localparam int FFGP_B_TMO = 7;
  localparam int FFGP_B_WAKE1 = 8;
  localparam int FFGP_B_WAKE2 = 9;
  localparam int FFGP_B_RSTW = 10;
  localparam int FFGP_NALL = 11;
  // Control fields
  localparam int FFGP_C_MODE_LO = 0;
  localparam int FFGP_C_MODE_HI = 1;
  localparam int FFGP_C_GPO = 2;
  localparam logic [1:0] FFGP_MODE_SUPPLY = 2'h0;
  localparam logic [1:0] FFGP_MODE_BUTTON = 2'h1;
  localparam logic [2:0] FFGP_CTRL_RST = 3'h4;
  // Timing (default durations)
  localparam int FFGP_CLK_MHZ = 100;
  localparam int FFGP_PULSE_US = 128;
  localparam int FFGP_PULSE_CYC = FFGP_PULSE_US * FFGP_CLK_MHZ;
  localparam int FFGP_WAKE1_MS = 500;
  localparam int FFGP_WAKE2_MS = 1000;
  localparam int FFGP_RSTW_MS = 6000;
  localparam int FFGP_CYC_PER_MS = 1000 * FFGP_CLK_MHZ;
  localparam int FFGP_TW = 32;
endpackage

// ==== ffgp_edge_if.sv ====
// Interface carrying one edge detector's input and output
`timescale 1ns/1ps
interface ffgp_edge_if;
  logic level;
  logic rise;
  modport det (input level, output rise);
  modport user (output level, input rise);
endinterface

// ==== ffgp_edge.sv ====
// Rising edge detector for one status condition
`timescale 1ns/1ps
module ffgp_edge (
  input wire logic pclk,
  input wire logic presetn,
  ffgp_edge_if.det e
);
  logic prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_r <= 1'b0;
    else prev_r <= e.level;
  end
  assign e.rise = e.level & ~prev_r;
endmodule // ffgp_edge

// ==== ffgp_hold_timer.sv ====
// Counts how long the button has stayed low
`timescale 1ns/1ps
module ffgp_hold_timer import ffgp_pkg::*; #(
  parameter int W = FFGP_TW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic button_low,
  output logic [W-1:0] held
);
  logic [W-1:0] held_r;
  logic [W-1:0] held_nxt;
  assign held_nxt = !button_low ? '0 : (&held_r ? held_r : held_r + W'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) held_r <= '0;
    else held_r <= held_nxt;
  end
  assign held = held_r;
endmodule // ffgp_hold_timer

// ==== ffgp_top.sv ====
// Fault flags, charger reaction and power-good indicator with APB registers
// What this block does
// - The warm-zone flag sets on the rising edge of the warm condition and charging goes on at reduced voltage.
// - The hot-zone flag sets on the rising edge of the hot condition and charging and timer pause meanwhile.
// - The conversion-ready flag sets on each conversion completion and touches nothing else.
// - The open-thermistor flag sets on the open condition and charging and timer pause meanwhile.
// - Timer expiry sets the timeout flag and stops charging until supply or enable toggles, which clears it.
// - Three button flags set after the button stays low for the wake one, wake two and warning times.
// - The indicator pin is open drain and by default shows a valid input supply.
// - In default mode the pin pulls low only while the supply is above lockout, above battery and below overvoltage.
// - In mode 01 the pin pulls low while the button is low and floats while it is high.
// - In mode 1x the pin pulls low when the host output bit is 0 and floats when it is 1.
// - A thermistor fault sends one 128 us pulse on the interrupt pulse output.
// - Fault flags stay set until the host reads them, and the read clears them; the timeout flag also clears on a supply or enable toggle.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module ffgp_top import ffgp_pkg::*; #(
  parameter int PULSE_CYC = FFGP_PULSE_CYC,
  parameter int WAKE1_CYC = FFGP_WAKE1_MS * FFGP_CYC_PER_MS,
  parameter int WAKE2_CYC = FFGP_WAKE2_MS * FFGP_CYC_PER_MS,
  parameter int RSTW_CYC = FFGP_RSTW_MS * FFGP_CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FFGP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ts_warm_zone,
  input wire logic ts_hot_zone,
  input wire logic ts_open,
  input wire logic adc_done,
  input wire logic compare_one_hit,
  input wire logic compare_two_hit,
  input wire logic compare_three_hit,
  input wire logic safety_timer_expired,
  input wire logic charge_enable_in,
  input wire logic input_supply_uvlo_ok,
  input wire logic input_supply_above_bat,
  input wire logic input_supply_below_ovp,
  input wire logic push_button_input_n,
  output logic charge_allowed,
  output logic reduce_reg_voltage,
  output logic safety_timer_pause,
  output logic safety_timer_reset,
  output logic fault_pulse,
  output logic irq,
  output logic power_good_indicator_o,
  output logic power_good_indicator_oe_n
);
  // Two-flop synchronisers for all thirteen status, supply and button inputs; the APB inputs are not synchronised
  localparam int NS = 13;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] raw;
  assign raw = {ts_warm_zone, ts_hot_zone, ts_open, adc_done, compare_one_hit, compare_two_hit,
                compare_three_hit, safety_timer_expired, charge_enable_in, input_supply_uvlo_ok,
                input_supply_above_bat, input_supply_below_ovp, push_button_input_n};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= {{(NS-1){1'b0}}, 1'b1};
      s2_r <= {{(NS-1){1'b0}}, 1'b1};
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  logic warm, hot, open_ts, adc, c1, c2, c3, expired, ce, uvlo_ok, above_bat, below_ovp, button_n;
  assign {warm, hot, open_ts, adc, c1, c2, c3, expired, ce, uvlo_ok, above_bat, below_ovp, button_n} = s2_r;
  logic supply_good;
  assign supply_good = uvlo_ok & above_bat & below_ovp;

  // Button hold times
  logic [FFGP_TW-1:0] held;
  ffgp_hold_timer #(.W(FFGP_TW)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .button_low(~button_n),
    .held(held)
  );
  logic wake1_lvl, wake2_lvl, rstw_lvl;
  assign wake1_lvl = held >= FFGP_TW'(WAKE1_CYC);
  assign wake2_lvl = held >= FFGP_TW'(WAKE2_CYC);
  assign rstw_lvl = held >= FFGP_TW'(RSTW_CYC);

  // Rising edge per condition
  logic [FFGP_NALL-1:0] cond;
  logic [FFGP_NALL-1:0] rise;
  assign cond = {rstw_lvl, wake2_lvl, wake1_lvl, expired, open_ts, c3, c2, c1, adc, hot, warm};
  genvar gi;
  generate
    for (gi = 0; gi < FFGP_NALL; gi++) begin : g_edge
      ffgp_edge_if eif();
      assign eif.level = cond[gi];
      ffgp_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .e(eif)
      );
      assign rise[gi] = eif.rise;
    end
  endgenerate

  // APB decode
  logic acc, wr, rd;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  logic hit_flags, hit_stat, hit_ctrl, hit_ist, hit_iclr, hit_ien, mapped;
  assign hit_flags = paddr == FFGP_ADDR_FLAGS;
  assign hit_stat = paddr == FFGP_ADDR_STAT;
  assign hit_ctrl = paddr == FFGP_ADDR_CTRL;
  assign hit_ist = paddr == FFGP_ADDR_IRQ_STAT;
  assign hit_iclr = paddr == FFGP_ADDR_IRQ_CLR;
  assign hit_ien = paddr == FFGP_ADDR_IRQ_EN;
  assign mapped = hit_flags | hit_stat | hit_ctrl | hit_ist | hit_iclr | hit_ien;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Flags: set on edge, cleared by read; set wins over the clear
  // Only bits already captured for the host clear, so a rise during setup survives
  logic [31:0] prdata_r;
  logic [FFGP_NALL-1:0] flags_r;
  logic [FFGP_NALL-1:0] flags_nxt;
  logic [FFGP_NALL-1:0] tmo_clr;
  logic [FFGP_NALL-1:0] rd_clr;
  logic supply_prev_r, ce_prev_r, toggle;
  assign toggle = (supply_good ^ supply_prev_r) | (ce ^ ce_prev_r);
  assign tmo_clr = toggle ? FFGP_NALL'(1) << FFGP_B_TMO : '0;
  assign rd_clr = (rd && hit_flags) ? prdata_r[FFGP_NALL-1:0] : '0;
  assign flags_nxt = rise | (flags_r & ~rd_clr & ~tmo_clr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
      supply_prev_r <= 1'b0;
      ce_prev_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      supply_prev_r <= supply_good;
      ce_prev_r <= ce;
    end
  end

  // Timeout latch: charging stays off until a toggle
  logic tmo_lock_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tmo_lock_r <= 1'b0;
    else if (rise[FFGP_B_TMO]) tmo_lock_r <= 1'b1;
    else if (toggle) tmo_lock_r <= 1'b0;
  end
  assign charge_allowed = supply_good & ce & ~tmo_lock_r & ~hot & ~open_ts;
  assign reduce_reg_voltage = warm & ~hot;
  assign safety_timer_pause = hot | open_ts;
  assign safety_timer_reset = tmo_lock_r;

  // Single thermistor fault pulse
  logic [FFGP_TW-1:0] pulse_cnt_r;
  logic ts_fault;
  assign ts_fault = rise[FFGP_B_WARM] | rise[FFGP_B_HOT] | rise[FFGP_B_OPEN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_cnt_r <= '0;
    else if (ts_fault && pulse_cnt_r == '0) pulse_cnt_r <= FFGP_TW'(PULSE_CYC);
    else if (pulse_cnt_r != '0) pulse_cnt_r <= pulse_cnt_r - FFGP_TW'(1);
  end
  assign fault_pulse = pulse_cnt_r != '0;

  // Sticky interrupt status, write-one clear, enable
  logic [FFGP_NALL-1:0] ist_r;
  logic [FFGP_NALL-1:0] ien_r;
  logic [FFGP_NALL-1:0] iclr;
  assign iclr = (wr && hit_iclr) ? pwdata[FFGP_NALL-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      ien_r <= '0;
    end else begin
      ist_r <= rise | (ist_r & ~iclr);
      if (wr && hit_ien) ien_r <= pwdata[FFGP_NALL-1:0];
    end
  end
  assign irq = |(ist_r & ien_r);

  // Indicator control register
  logic [2:0] ctrl_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= FFGP_CTRL_RST;
    else if (wr && hit_ctrl) ctrl_r <= pwdata[2:0];
  end
  logic [1:0] mode;
  logic pull_low;
  assign mode = ctrl_r[FFGP_C_MODE_HI:FFGP_C_MODE_LO];
  assign pull_low = mode[1] ? ~ctrl_r[FFGP_C_GPO] :
                    (mode == FFGP_MODE_BUTTON) ? ~button_n :
                    supply_good;
  logic pull_low_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pull_low_r <= 1'b0;
    else pull_low_r <= pull_low;
  end
  assign power_good_indicator_o = 1'b0;
  assign power_good_indicator_oe_n = ~pull_low_r;

  // Read data
  logic [31:0] rdata;
  assign rdata = hit_flags ? 32'(flags_r) :
                 hit_stat ? 32'({tmo_lock_r, supply_good, button_n, open_ts, hot, warm}) :
                 hit_ctrl ? 32'(ctrl_r) :
                 hit_ist ? 32'(ist_r) :
                 hit_ien ? 32'(ien_r) : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_r <= rdata;
  end
  assign prdata = prdata_r;
endmodule // ffgp_top

// ==== ffgp_props.sv ====
// Concurrent checks on the fault flag and indicator block ports
`timescale 1ns/1ps
module ffgp_props import ffgp_pkg::*; #(
  parameter int PULSE_CYC = FFGP_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [FFGP_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ts_warm_zone,
  input wire logic ts_hot_zone,
  input wire logic ts_open,
  input wire logic safety_timer_expired,
  input wire logic push_button_input_n,
  input wire logic input_supply_uvlo_ok,
  input wire logic charge_allowed,
  input wire logic reduce_reg_voltage,
  input wire logic safety_timer_pause,
  input wire logic fault_pulse,
  input wire logic irq,
  input wire logic power_good_indicator_o,
  input wire logic power_good_indicator_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [15:0] cnt_r;
  logic [2:0] ctrl_r;
  logic [1:0] mode;
  // Indicator control as last written by the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= FFGP_CTRL_RST;
    else if (psel && penable && pwrite && paddr == FFGP_ADDR_CTRL) ctrl_r <= pwdata[2:0];
  end
  assign mode = ctrl_r[FFGP_C_MODE_HI:FFGP_C_MODE_LO];
  // Length of the current fault pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 16'h0;
    else cnt_r <= fault_pulse ? cnt_r + 16'h1 : 16'h0;
  end
  a_slverr_unmapped: assert property (psel && penable && !mapped |-> pslverr) else $error("no error on unmapped");
  a_ready_no_wait: assert property (psel && penable |-> pready) else $error("access stalled");
  a_warm_reduces_voltage: assert property ((ts_warm_zone && !ts_hot_zone)[*4] |-> reduce_reg_voltage)
    else $error("warm zone not reducing");
  a_hot_pauses_charge: assert property (ts_hot_zone[*4] |-> safety_timer_pause && !charge_allowed)
    else $error("hot zone not pausing");
  a_open_pauses_charge: assert property (ts_open[*4] |-> safety_timer_pause && !charge_allowed)
    else $error("open sensor not pausing");
  a_timeout_stops_charge: assert property (safety_timer_expired[*4] |-> !charge_allowed)
    else $error("charging after timeout");
  a_pulse_exact_width: assert property ($fell(fault_pulse) |-> cnt_r == PULSE_CYC)
    else $error("fault pulse width wrong");
  a_irq_mask_off: assert property (psel && penable && pwrite && paddr == 8'h14 && pwdata[10:0] == 11'h0 |=> !irq)
    else $error("masked irq still high");
  a_pin_drives_low: assert property (power_good_indicator_o == 1'b0)
    else $error("indicator driven high");
  a_pin_gpo_mode: assert property (mode[1] && $stable(ctrl_r) |-> power_good_indicator_oe_n == ctrl_r[FFGP_C_GPO])
    else $error("indicator not following host bit");
  a_pin_button_mode: assert property ((mode == FFGP_MODE_BUTTON && $stable(push_button_input_n))[*4] |->
    power_good_indicator_oe_n == push_button_input_n) else $error("indicator not following button");
  a_pin_supply_low: assert property ((mode == FFGP_MODE_SUPPLY && !input_supply_uvlo_ok)[*4] |->
    power_good_indicator_oe_n) else $error("indicator pulled without supply");
endmodule // ffgp_props
bind ffgp_top ffgp_props #(.PULSE_CYC(PULSE_CYC)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .ts_warm_zone(ts_warm_zone), .ts_hot_zone(ts_hot_zone), .ts_open(ts_open),
  .safety_timer_expired(safety_timer_expired), .push_button_input_n(push_button_input_n),
  .input_supply_uvlo_ok(input_supply_uvlo_ok), .charge_allowed(charge_allowed),
  .reduce_reg_voltage(reduce_reg_voltage), .safety_timer_pause(safety_timer_pause),
  .fault_pulse(fault_pulse), .irq(irq), .power_good_indicator_o(power_good_indicator_o),
  .power_good_indicator_oe_n(power_good_indicator_oe_n));

// ==== ffgp_pin_load.sv ====
// Pull-up load on the open-drain indicator pin
`timescale 1ns/1ps
module ffgp_pin_load (
  input wire logic drive_o,
  input wire logic drive_oe_n,
  output logic pin
);
  assign pin = drive_oe_n ? 1'b1 : drive_o;
endmodule // ffgp_pin_load

// ==== tb_top.sv ====
// Self-checking bench for the fault flag and indicator block
`timescale 1ns/1ps
module tb_top;
  import ffgp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1, btn_n = 1, err;
  logic [7:0] paddr = 0, cond = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] sup = 3'h7;
  wire [31:0] prdata;
  wire pready, pslverr, ca, rv, sp, tr, fp, irq, pgo, pgoe, pin;
  int n_fail = 0, num_checks = 0, seed = 71, cyc = 0, r;
  initial forever #5 pclk = ~pclk;
  ffgp_top #(.PULSE_CYC(20), .WAKE1_CYC(40), .WAKE2_CYC(60), .RSTW_CYC(80)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ts_warm_zone(cond[0]), .ts_hot_zone(cond[1]), .ts_open(cond[6]),
    .adc_done(cond[2]), .compare_one_hit(cond[3]), .compare_two_hit(cond[4]), .compare_three_hit(cond[5]),
    .safety_timer_expired(cond[7]), .charge_enable_in(ce), .input_supply_uvlo_ok(sup[0]),
    .input_supply_above_bat(sup[1]), .input_supply_below_ovp(sup[2]), .push_button_input_n(btn_n),
    .charge_allowed(ca), .reduce_reg_voltage(rv), .safety_timer_pause(sp), .safety_timer_reset(tr),
    .fault_pulse(fp), .irq(irq), .power_good_indicator_o(pgo), .power_good_indicator_oe_n(pgoe));
  ffgp_pin_load i_load (.drive_o(pgo), .drive_oe_n(pgoe), .pin(pin));
  task results;
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Pin model: high when released, low when pulled
  function logic exp_pin(input logic [2:0] c, input logic b, input logic [2:0] s);
    exp_pin = c[1] ? c[2] : (c[0] ? b : ~&s);
  endfunction
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    w(16);
    presetn <= 1;
    apb(0, FFGP_ADDR_CTRL, 0); chk(rd, 32'h4);
    apb(0, FFGP_ADDR_IRQ_EN, 0); chk(rd, 32'h0);
    apb(0, 8'h40, 0); chk({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      apb(1, FFGP_ADDR_CTRL, {r[2], i[1:0]});
      btn_n <= r[3]; sup <= r[6:4];
      w(5); chk(pin, exp_pin({r[2], i[1:0]}, r[3], r[6:4]));
    end
    sup <= 3'h7;
    btn_n <= 1;
    w(5);
    apb(0, FFGP_ADDR_FLAGS, 0);
    for (int i = 0; i < 8; i++) begin
      cond[i] <= 1;
      w(5); chk({sp, rv, ca, fp}, {i == 1 || i == 6, i == 0, !(i == 1 || i == 6 || i == 7), i < 2 || i == 6});
      apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h1 << i);
      apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h0);
      cond[i] <= 0;
      w(25);
    end
    chk(ca, 1'b0);
    chk(tr, 1'b1);
    cond[7] <= 1; ce <= 0;
    w(4); ce <= 1; cond[7] <= 0;
    w(5); chk(ca, 1'b1);
    chk(tr, 1'b0);
    apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h0);
    btn_n <= 0;
    w(50); apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h100);
    w(40); apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h600);
    btn_n <= 1;
    cond[2] <= 1;
    w(1);
    apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h0);
    apb(0, FFGP_ADDR_FLAGS, 0); chk(rd, 32'h4);
    cond[2] <= 0;
    apb(1, FFGP_ADDR_IRQ_CLR, 32'h7FF);
    apb(1, FFGP_ADDR_IRQ_EN, 32'h7FF); w(1); chk(irq, 1'b0);
    cond[2] <= 1;
    w(5); chk(irq, 1'b1);
    apb(0, FFGP_ADDR_IRQ_STAT, 0); chk(rd, 32'h4);
    apb(1, FFGP_ADDR_IRQ_EN, 0); w(1); chk(irq, 1'b0);
    apb(1, FFGP_ADDR_IRQ_EN, 32'h4); w(1); chk(irq, 1'b1);
    apb(1, FFGP_ADDR_IRQ_CLR, 32'h4); w(1); chk(irq, 1'b0);
    results;
  end
endmodule // tb_top
